// [verif/rsm_chip_src.sv]
// Chip stream source standing in for the receiver baseband slicer.
// Assumes one chip per hclk cycle while run is high, same clock as the block.
module rsm_chip_src (
	// Clock
	input  wire logic       hclk,
	// Control from bench
	input  wire logic       run,
	input  wire logic [1:0] pat,
	// Chip stream
	output logic            chip_valid,
	output logic            chip_value
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] left    = 2'h1;
	logic       alt     = 1'b0;
	logic       valid_q = 1'b0;
	logic       level_q = 1'b0;

	assign chip_valid = valid_q;
	assign chip_value = level_q;

	// Run lengths: pat 0 one chip, 1 two chips, 2 alternating two and one.
	// Outside a burst the level keeps toggling so no stale chip looks valid;
	// a one-chip reload there makes the first valid chip open a fresh run.
	always @(posedge hclk) begin
		valid_q <= run;
		if (!run || left == 2'h1) begin
			level_q <= ~level_q;
			alt     <= ~alt;
			left    <= (!run || pat == 2'h0 || (pat == 2'h2 && alt)) ? 2'h1 : 2'h2;
		end else begin
			left <= left - 2'h1;
		end
	end
endmodule

// [verif/test_rx_signal_monitor_control.sv]
// Self-checking bench for the receiver signal monitor control block.
// Assumes a zero-wait AHB-Lite slave and one 50 MHz clock.
module test_rx_signal_monitor_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic        hclk, hresetn, hsel, hwrite, hready;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp;
	logic        wakeup_start, preamble_start, data_start, phase_stop, timer_expired;
	logic [6:1]  mon_pass, mon_fail, data_monitor_enables, active_monitor_enables;
	logic        chip_valid, chip_value, src_run;
	logic [1:0]  src_pat, data_expected_gap_count;
	logic        timeout_armed, wakeup_done, wakeup_passed, preamble_fail, data_eof;
	logic        slicer_level, slicer_lpf, slicer_lpf_long, irq;
	int          err_count, samples_checked, done_cnt, fail_cnt;
	logic [31:0] v;

	assign hready = hreadyout;

	rsm_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.wakeup_start(wakeup_start), .preamble_start(preamble_start),
		.data_start(data_start), .phase_stop(phase_stop), .timer_expired(timer_expired),
		.mon_pass(mon_pass), .mon_fail(mon_fail),
		.data_monitor_enables(data_monitor_enables), .chip_valid(chip_valid),
		.chip_value(chip_value), .active_monitor_enables(active_monitor_enables),
		.timeout_armed(timeout_armed), .wakeup_done(wakeup_done),
		.wakeup_passed(wakeup_passed), .preamble_fail(preamble_fail),
		.data_eof(data_eof), .data_expected_gap_count(data_expected_gap_count),
		.slicer_level(slicer_level), .slicer_lpf(slicer_lpf),
		.slicer_lpf_long(slicer_lpf_long), .irq(irq));

	rsm_chip_src src_u (.hclk(hclk), .run(src_run), .pat(src_pat),
		.chip_valid(chip_valid), .chip_value(chip_value));

	always #10 hclk = ~hclk;

	// Registered results are read before the edge updates them, so counts lag one edge
	always @(posedge hclk) begin
		if (wakeup_done === 1'b1)
			done_cnt++;
		if ((wakeup_done === 1'b1 && wakeup_passed === 1'b0) || preamble_fail === 1'b1
			|| data_eof === 1'b1)
			fail_cnt++;
	end

	task automatic report_and_stop;
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// One AHB single transfer; data phase result returned for reads
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		chk(hresp, 0);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d, v);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		xfer(1'b0, idx, 32'h0, v);
		chk(v, e);
	endtask

	task automatic pulse(input int which);
		case (which)
			0: wakeup_start <= 1'b1;
			1: preamble_start <= 1'b1;
			2: data_start <= 1'b1;
			default: phase_stop <= 1'b1;
		endcase
		@(posedge hclk);
		{wakeup_start, preamble_start, data_start, phase_stop} <= 4'h0;
		wt(3);
	endtask

	task automatic t_regs;
		rd(rsm_pkg::IDX_DATA_RX, 32'h0);
		rd(rsm_pkg::IDX_WAKEUP, 32'h0);
		rd(rsm_pkg::IDX_PREAMBLE, 32'h0);
		wr(rsm_pkg::IDX_WAKEUP, 32'hff);
		rd(rsm_pkg::IDX_WAKEUP, 32'hfe);
		rd(8'h30, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(rsm_pkg::IDX_DATA_RX, {24'h0, k[1:0], k[1:0], 4'h5});
			wt(3);
			chk(data_expected_gap_count, k);
			chk({slicer_level, slicer_lpf, slicer_lpf_long}, {k != 0, k[1], k == 3});
			rd(rsm_pkg::IDX_DATA_RX, {24'h0, k[1:0], k[1:0], 4'h5});
		end
	endtask

	task automatic t_wake_mode0;
		int d;
		d = done_cnt;
		wr(rsm_pkg::IDX_WAKEUP, 32'h0c);
		pulse(0);
		chk(active_monitor_enables, 6'h06);
		mon_pass <= 6'h02;
		mon_fail <= 6'h10;
		wt(4);
		chk(done_cnt - d, 0);
		mon_fail <= 6'h04;
		wt(4);
		chk(done_cnt - d, 1);
		chk(wakeup_passed, 0);
		chk(active_monitor_enables, 6'h00);
		mon_fail <= 6'h00;
		pulse(0);
		mon_pass <= 6'h06;
		wt(4);
		chk(done_cnt - d, 2);
		chk(wakeup_passed, 1);
		mon_pass <= 6'h00;
		wt(2);
	endtask

	task automatic t_irq;
		rd(rsm_pkg::IDX_STATUS, 32'h3);
		chk(irq, 0);
		wr(rsm_pkg::IDX_MASK, 32'h1);
		wt(3);
		chk(irq, 1);
		wr(rsm_pkg::IDX_STATUS, 32'h1);
		wt(3);
		chk(irq, 0);
		rd(rsm_pkg::IDX_STATUS, 32'h2);
		wr(rsm_pkg::IDX_STATUS, 32'h2);
		wr(rsm_pkg::IDX_MASK, 32'h0);
	endtask

	task automatic t_wake_mode1;
		int d;
		d = done_cnt;
		wr(rsm_pkg::IDX_WAKEUP, 32'h8c);
		pulse(0);
		chk(timeout_armed, 0);
		mon_fail <= 6'h06;
		timer_expired <= 1'b1;
		wt(4);
		chk(done_cnt - d, 0);
		mon_fail <= 6'h00;
		timer_expired <= 1'b0;
		wr(rsm_pkg::IDX_TIMEOUT, 32'h05);
		wt(3);
		chk(timeout_armed, 1);
		timer_expired <= 1'b1;
		@(posedge hclk);
		timer_expired <= 1'b0;
		wt(3);
		chk(done_cnt - d, 1);
		chk(wakeup_passed, 0);
	endtask

	task automatic t_preamble;
		int d;
		wr(rsm_pkg::IDX_PREAMBLE, 32'hff);
		pulse(1);
		chk(active_monitor_enables, 6'h3f);
		chk(timeout_armed, 1);
		d = fail_cnt;
		timer_expired <= 1'b1;
		@(posedge hclk);
		timer_expired <= 1'b0;
		wt(3);
		chk(fail_cnt - d, 1);
		mon_fail <= 6'h02;
		@(posedge hclk);
		mon_fail <= 6'h10;
		@(posedge hclk);
		mon_fail <= 6'h00;
		wt(2);
		rd(rsm_pkg::IDX_ACCUM, 32'h24);
		rd(rsm_pkg::IDX_ACCUM, 32'h0);
		mon_fail <= 6'h01;
		@(posedge hclk);
		mon_fail <= 6'h00;
		wt(2);
		pulse(1);
		rd(rsm_pkg::IDX_ACCUM, 32'h0);
		wr(rsm_pkg::IDX_PREAMBLE, 32'h7e);
		wt(3);
		chk(timeout_armed, 0);
		d = fail_cnt;
		timer_expired <= 1'b1;
		@(posedge hclk);
		timer_expired <= 1'b0;
		wt(3);
		chk(fail_cnt - d, 0);
		pulse(3);
	endtask

	task automatic t_data_eof;
		int d;
		data_monitor_enables <= 6'h01;
		pulse(2);
		d = fail_cnt;
		mon_fail <= 6'h02;
		wt(3);
		chk(fail_cnt - d, 0);
		mon_fail <= 6'h01;
		@(posedge hclk);
		mon_fail <= 6'h00;
		wt(3);
		chk(fail_cnt - d, 1);
		pulse(3);
	endtask

	// One coding run: phase, coding policy bits, chip pattern, failure expected
	task automatic t_coding(input int ph, input logic [7:0] cfg, input logic [1:0] pat,
		input logic e);
		int d;
		wr(rsm_pkg::IDX_DATA_RX, {24'h0, cfg});
		d = fail_cnt;
		pulse(ph);
		src_pat <= pat;
		src_run <= 1'b1;
		wt(30);
		src_run <= 1'b0;
		wt(3);
		chk(fail_cnt != d, e);
		pulse(3);
	endtask

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = {4'h0, 3'h2, 64'h0};
		{wakeup_start, preamble_start, data_start, phase_stop, timer_expired} = 5'h0;
		{mon_pass, mon_fail, data_monitor_enables} = 18'h0;
		{src_run, src_pat} = 3'h0;
		wt(3);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_wake_mode0;
		t_irq;
		t_wake_mode1;
		t_preamble;
		t_data_eof;
		wr(rsm_pkg::IDX_WAKEUP, 32'h10);
		wr(rsm_pkg::IDX_PREAMBLE, 32'h10);
		data_monitor_enables <= 6'h08;
		t_coding(0, 8'h00, 2'h0, 1'b0);
		t_coding(0, 8'h04, 2'h1, 1'b1);
		t_coding(0, 8'h08, 2'h0, 1'b1);
		t_coding(0, 8'h08, 2'h1, 1'b0);
		t_coding(0, 8'h0c, 2'h0, 1'b0);
		t_coding(0, 8'h0c, 2'h2, 1'b1);
		t_coding(0, 8'h00, 2'h2, 1'b0);
		t_coding(1, 8'h00, 2'h2, 1'b0);
		t_coding(1, 8'h02, 2'h2, 1'b1);
		t_coding(2, 8'h00, 2'h2, 1'b0);
		t_coding(2, 8'h01, 2'h2, 1'b1);
		report_and_stop;
	end

	// Whole run is well under a thousand cycles; give it ample margin
	initial begin
		#400000;
		err_count++;
		report_and_stop;
	end
endmodule

// [verilog/rsm_coding_check.sv]
// Chip interval coding verifier.
// Assumes chip samples arrive on hclk with a one-cycle valid strobe.
module rsm_coding_check (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Chip stream
	input  wire logic       chip_valid,
	input  wire logic       chip_value,
	input  wire logic       restart,
	// Policy and result
	input  wire logic [1:0] policy,
	output logic            interval_err
);

	logic       last_reg, last_next;
	logic [1:0] run_reg, run_next;
	logic       first_reg, first_next;
	logic       half_reg, half_next;
	logic       sync_reg, sync_next;
	logic       err_reg, err_next;
	logic       is_short, is_long;

	assign is_short = (run_reg == 2'h1);
	assign is_long  = (run_reg == 2'h2);

	always_comb begin
		last_next  = last_reg;
		run_next   = run_reg;
		first_next = first_reg;
		half_next  = half_reg;
		sync_next  = sync_reg;
		err_next   = 1'b0;
		if (restart) begin
			first_next = 1'b1;
			sync_next  = 1'b0;
			half_next  = 1'b0;
		end else if (chip_valid) begin
			if (first_reg) begin
				first_next = 1'b0;
				last_next  = chip_value;
				run_next   = 2'h1;
			end else if (chip_value == last_reg) begin
				// Saturate: anything past two chips is simply too long
				if (run_reg != 2'h3)
					run_next = run_reg + 2'h1;
			end else begin
				last_next = chip_value;
				run_next  = 2'h1;
				case (policy) // see R03
					rsm_pkg::COD_ANY:   err_next = !(is_short || is_long);
					rsm_pkg::COD_SHORT: err_next = !is_short;
					rsm_pkg::COD_LONG:  err_next = !is_long;
					default: begin
						// A long interval must start at a bit centre
						err_next = !(is_short || is_long) || (is_long && sync_reg && !half_reg);
						if (is_short)
							half_next = !half_reg;
						if (is_long) begin
							sync_next = 1'b1;
							half_next = 1'b1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_reg  <= 1'b0;
			run_reg   <= 2'h0;
			first_reg <= 1'b1;
			half_reg  <= 1'b0;
			sync_reg  <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			last_reg  <= last_next;
			run_reg   <= run_next;
			first_reg <= first_next;
			half_reg  <= half_next;
			sync_reg  <= sync_next;
			err_reg   <= err_next;
		end
	end

	assign interval_err = err_reg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	short_only_a: assert property (chip_valid && !restart && !first_reg && chip_value != last_reg // see R03
		&& policy == rsm_pkg::COD_SHORT && is_long |=> interval_err)
		else $error("long interval accepted under short-only policy");

endmodule

// [verilog/rsm_ctrl.sv]
// Receiver signal monitor control: phase sequencing, monitor selection,
// coding policy, wakeup decision, preamble error accumulation, registers.
// Assumes phase starts, monitor verdicts and chips are on hclk.
module rsm_ctrl (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Phase control
	input  wire logic        wakeup_start,
	input  wire logic        preamble_start,
	input  wire logic        data_start,
	input  wire logic        phase_stop,
	input  wire logic        timer_expired,
	// Monitor verdicts, bit n for monitor n
	input  wire logic [6:1]  mon_pass,
	input  wire logic [6:1]  mon_fail,
	input  wire logic [6:1]  data_monitor_enables,
	// Chip stream
	input  wire logic        chip_valid,
	input  wire logic        chip_value,
	// Results
	output logic [6:1]       active_monitor_enables,
	output logic             timeout_armed,
	output logic             wakeup_done,
	output logic             wakeup_passed,
	output logic             preamble_fail,
	output logic             data_eof,
	output logic [1:0]       data_expected_gap_count,
	output logic             slicer_level,
	output logic             slicer_lpf,
	output logic             slicer_lpf_long,
	output logic             irq
);

	rsm_pkg::rsm_phase_t phase_reg, phase_next;

	logic [7:0]  data_rx_reg, data_rx_next;
	logic [7:0]  wakeup_reg, wakeup_next;
	logic [7:0]  preamble_reg, preamble_next;
	logic [5:0]  timeout_reg, timeout_next;
	logic [rsm_pkg::ST_W-1:0] status_reg, status_next;
	logic [rsm_pkg::ST_W-1:0] mask_reg, mask_next;
	logic [6:1]  accum_reg, accum_next;
	logic        wr_pend_reg, wr_pend_next;
	logic [7:0]  wr_idx_reg, wr_idx_next;
	logic [31:0] hrdata_reg, hrdata_next;

	logic [6:1]  en_reg, en_next;
	logic        armed_reg, armed_next;
	logic        done_reg, done_next;
	logic        passed_reg, passed_next;
	logic        pfail_reg, pfail_next;
	logic        eof_reg, eof_next;
	logic [1:0]  gap_reg, gap_next;
	logic [2:0]  slc_reg, slc_next;
	logic        irq_reg, irq_next;
	logic        hreadyout_reg;
	logic        hresp_reg;

	logic        addr_ok, rd_accept, wr_data;
	logic [7:0]  a_idx;
	logic [1:0]  cod_policy;
	logic        coding_err;
	logic [6:1]  fails, cur_en;
	logic        all_pass, any_fail, timed_out, start_any;
	logic [1:0]  slc_sel;
	logic [rsm_pkg::ST_W-1:0] events, st_clear;

	// Bus decode
	assign addr_ok   = hsel && htrans[1] && hready;
	assign a_idx     = haddr[rsm_pkg::ADDR_LSB +: 8];
	assign rd_accept = addr_ok && !hwrite;
	assign wr_data   = wr_pend_reg;
	assign start_any = wakeup_start || preamble_start || data_start;

	// Coding policy of the running phase
	always_comb begin
		case (phase_reg)
			rsm_pkg::PH_WAKEUP: cod_policy = data_rx_reg[rsm_pkg::CODW_HI:rsm_pkg::CODW_LO]; // see R03
			rsm_pkg::PH_PREAMBLE: cod_policy = data_rx_reg[rsm_pkg::CODP_BIT] ? // see R04
				rsm_pkg::COD_MANCH : rsm_pkg::COD_ANY;
			default: cod_policy = data_rx_reg[rsm_pkg::CODD_BIT] ? // see R05
				rsm_pkg::COD_MANCH : rsm_pkg::COD_ANY;
		endcase
	end

	rsm_coding_check u_coding (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.chip_valid   (chip_valid && phase_reg != rsm_pkg::PH_IDLE),
		.chip_value   (chip_value),
		.restart      (start_any),
		.policy       (cod_policy),
		.interval_err (coding_err)
	);

	// Verdicts of the enabled monitors; our verifier feeds the coding monitor
	always_comb begin
		fails = mon_fail;
		fails[rsm_pkg::MON_CODING] = mon_fail[rsm_pkg::MON_CODING] || coding_err;
		case (phase_reg)
			rsm_pkg::PH_WAKEUP:   cur_en = wakeup_reg[rsm_pkg::MON_HI:rsm_pkg::MON_LO];   // see R08
			rsm_pkg::PH_PREAMBLE: cur_en = preamble_reg[rsm_pkg::MON_HI:rsm_pkg::MON_LO]; // see R09
			rsm_pkg::PH_DATA:     cur_en = data_monitor_enables;
			default:              cur_en = '0;
		endcase
	end

	assign all_pass  = &(mon_pass | ~cur_en);
	assign any_fail  = |(fails & cur_en);
	assign timed_out = timer_expired && (timeout_reg != '0); // see R14

	// Phase sequencing and decisions
	always_comb begin
		phase_next  = phase_reg;
		done_next   = 1'b0;
		passed_next = passed_reg;
		pfail_next  = 1'b0;
		eof_next    = 1'b0;
		accum_next  = accum_reg;
		case (phase_reg)
			rsm_pkg::PH_WAKEUP: begin
				if (all_pass) begin // see R06 R07
					done_next   = 1'b1;
					passed_next = 1'b1;
					phase_next  = rsm_pkg::PH_IDLE;
				end else if (wakeup_reg[rsm_pkg::MODE_BIT] ? timed_out : any_fail) begin // see R06 R07
					done_next   = 1'b1;
					passed_next = 1'b0;
					phase_next  = rsm_pkg::PH_IDLE;
				end
			end
			rsm_pkg::PH_PREAMBLE: begin
				// Timeout reuse counts as a preamble failure
				pfail_next = any_fail || (preamble_reg[rsm_pkg::REUSE_BIT] && timed_out); // see R10
			end
			rsm_pkg::PH_DATA: begin
				eof_next = any_fail; // see R15
			end
			default: begin
			end
		endcase
		if (phase_reg == rsm_pkg::PH_PREAMBLE) begin
			// Set wins over the read clear so no error slips through
			if (preamble_reg[rsm_pkg::ACCU_BIT])
				accum_next = (rd_accept && a_idx == rsm_pkg::IDX_ACCUM ? '0 : accum_reg) // see R11 R12
					| (fails & cur_en);
			else
				accum_next = fails & cur_en;
		end else if (rd_accept && a_idx == rsm_pkg::IDX_ACCUM) begin
			accum_next = '0; // see R12
		end
		if (wakeup_start) begin
			phase_next = rsm_pkg::PH_WAKEUP;
		end else if (preamble_start) begin
			phase_next = rsm_pkg::PH_PREAMBLE;
			accum_next = '0; // see R12
		end else if (data_start) begin
			phase_next = rsm_pkg::PH_DATA;
		end else if (phase_stop) begin
			phase_next = rsm_pkg::PH_IDLE;
		end
	end

	// Outputs derived from configuration
	assign slc_sel = data_rx_reg[rsm_pkg::SLC_HI:rsm_pkg::SLC_LO]; // see R02

	always_comb begin
		en_next    = cur_en;
		armed_next = (timeout_reg != '0) && (phase_reg == rsm_pkg::PH_WAKEUP // see R14
			|| (phase_reg == rsm_pkg::PH_PREAMBLE && preamble_reg[rsm_pkg::REUSE_BIT])); // see R10
		gap_next   = data_rx_reg[rsm_pkg::GAP_HI:rsm_pkg::GAP_LO]; // see R01
		slc_next   = {slc_sel != rsm_pkg::SLC_EDGE, // see R13
			slc_sel == rsm_pkg::SLC_LPF_SHRT || slc_sel == rsm_pkg::SLC_LPF_LONG,
			slc_sel == rsm_pkg::SLC_LPF_LONG};
	end

	// Register writes, one cycle after the address phase
	assign events   = {eof_next, pfail_next, done_next && !passed_next, done_next && passed_next};
	assign st_clear = (wr_data && wr_idx_reg == rsm_pkg::IDX_STATUS) ?
		hwdata[rsm_pkg::ST_W-1:0] : '0;

	always_comb begin
		data_rx_next  = data_rx_reg;
		wakeup_next   = wakeup_reg;
		preamble_next = preamble_reg;
		timeout_next  = timeout_reg;
		mask_next     = mask_reg;
		if (wr_data) begin
			if (wr_idx_reg == rsm_pkg::IDX_DATA_RX)
				data_rx_next = hwdata[7:0];
			else if (wr_idx_reg == rsm_pkg::IDX_WAKEUP)
				wakeup_next = hwdata[7:0] & rsm_pkg::WAKEUP_WMASK; // see R16
			else if (wr_idx_reg == rsm_pkg::IDX_PREAMBLE)
				preamble_next = hwdata[7:0];
			else if (wr_idx_reg == rsm_pkg::IDX_TIMEOUT)
				timeout_next = hwdata[5:0];
			else if (wr_idx_reg == rsm_pkg::IDX_MASK)
				mask_next = hwdata[rsm_pkg::ST_W-1:0];
		end
		// Write-one-to-clear; a new event in the same cycle wins
		status_next  = (status_reg & ~st_clear) | events;
		irq_next     = |(status_next & mask_next);
		wr_pend_next = addr_ok && hwrite;
		wr_idx_next  = a_idx;
		// Read data from next values, accumulator from its register, so a write just before is seen
		hrdata_next  = hrdata_reg;
		if (rd_accept) begin
			if (a_idx == rsm_pkg::IDX_DATA_RX)
				hrdata_next = {24'h000000, data_rx_next};
			else if (a_idx == rsm_pkg::IDX_WAKEUP)
				hrdata_next = {24'h000000, wakeup_next}; // see R16
			else if (a_idx == rsm_pkg::IDX_PREAMBLE)
				hrdata_next = {24'h000000, preamble_next};
			else if (a_idx == rsm_pkg::IDX_TIMEOUT)
				hrdata_next = {26'h0, timeout_next};
			else if (a_idx == rsm_pkg::IDX_STATUS)
				hrdata_next = {28'h0000000, status_next};
			else if (a_idx == rsm_pkg::IDX_MASK)
				hrdata_next = {28'h0000000, mask_next};
			else if (a_idx == rsm_pkg::IDX_ACCUM)
				hrdata_next = {25'h0, accum_reg, 1'b0}; // see R12
			else
				hrdata_next = 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg     <= rsm_pkg::PH_IDLE;
			data_rx_reg   <= rsm_pkg::RST_DATA_RX;
			wakeup_reg    <= rsm_pkg::RST_WAKEUP;
			preamble_reg  <= rsm_pkg::RST_PREAMBLE;
			timeout_reg   <= rsm_pkg::RST_TIMEOUT;
			status_reg    <= '0;
			mask_reg      <= '0;
			accum_reg     <= '0;
			wr_pend_reg   <= 1'b0;
			wr_idx_reg    <= 8'h00;
			hrdata_reg    <= 32'h00000000;
			en_reg        <= '0;
			armed_reg     <= 1'b0;
			done_reg      <= 1'b0;
			passed_reg    <= 1'b0;
			pfail_reg     <= 1'b0;
			eof_reg       <= 1'b0;
			gap_reg       <= 2'h0;
			slc_reg       <= 3'h0;
			irq_reg       <= 1'b0;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end else begin
			phase_reg     <= phase_next;
			data_rx_reg   <= data_rx_next;
			wakeup_reg    <= wakeup_next;
			preamble_reg  <= preamble_next;
			timeout_reg   <= timeout_next;
			status_reg    <= status_next;
			mask_reg      <= mask_next;
			accum_reg     <= accum_next;
			wr_pend_reg   <= wr_pend_next;
			wr_idx_reg    <= wr_idx_next;
			hrdata_reg    <= hrdata_next;
			en_reg        <= en_next;
			armed_reg     <= armed_next;
			done_reg      <= done_next;
			passed_reg    <= passed_next;
			pfail_reg     <= pfail_next;
			eof_reg       <= eof_next;
			gap_reg       <= gap_next;
			slc_reg       <= slc_next;
			irq_reg       <= irq_next;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end
	end

	assign hrdata                  = hrdata_reg;
	assign hreadyout               = hreadyout_reg;
	assign hresp                   = hresp_reg;
	assign active_monitor_enables  = en_reg;
	assign timeout_armed           = armed_reg;
	assign wakeup_done             = done_reg;
	assign wakeup_passed           = passed_reg;
	assign preamble_fail           = pfail_reg;
	assign data_eof                = eof_reg;
	assign data_expected_gap_count = gap_reg;
	assign {slicer_level, slicer_lpf, slicer_lpf_long} = slc_reg;
	assign irq                     = irq_reg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence in_wakeup_quiet;
		phase_reg == rsm_pkg::PH_WAKEUP && !start_any;
	endsequence
	sequence wake_rd;
		rd_accept && a_idx == rsm_pkg::IDX_WAKEUP;
	endsequence

	wake_pass_a: assert property (in_wakeup_quiet and all_pass |=> wakeup_done && wakeup_passed) // see R06
		else $error("wakeup did not pass with all monitors passing");
	pess_fail_a: assert property (in_wakeup_quiet and (!wakeup_reg[rsm_pkg::MODE_BIT] // see R06
		&& any_fail && !all_pass) |=> wakeup_done && !wakeup_passed)
		else $error("pessimistic wakeup missed a fail");
	opt_hold_a: assert property (in_wakeup_quiet and (wakeup_reg[rsm_pkg::MODE_BIT] // see R07
		&& !all_pass && !timed_out) |=> !wakeup_done)
		else $error("optimistic wakeup ended without timer");
	opt_timeout_a: assert property (in_wakeup_quiet and (wakeup_reg[rsm_pkg::MODE_BIT] // see R07
		&& !all_pass && timed_out) |=> wakeup_done && !wakeup_passed)
		else $error("optimistic wakeup ignored timer expiry");
	bit0_zero_a: assert property (wake_rd ##1 1'b1 |-> hrdata[0] == 1'b0) // see R16
		else $error("wakeup register bit zero read as one");
	tmo_zero_a: assert property (timeout_reg == '0 |=> !timeout_armed) // see R14
		else $error("timer armed with zero timeout");
	accu_start_a: assert property (preamble_start && !wakeup_start |=> accum_reg == '0) // see R12
		else $error("accumulator not cleared at preamble start");
	eof_flag_a: assert property (phase_reg == rsm_pkg::PH_DATA && !start_any && any_fail // see R15
		|=> data_eof ##1 status_reg[rsm_pkg::ST_DATA_EOF])
		else $error("data monitor fault lost");
	enable_map_a: assert property (phase_reg == rsm_pkg::PH_PREAMBLE // see R09
		|=> active_monitor_enables == $past(preamble_reg[rsm_pkg::MON_HI:rsm_pkg::MON_LO]))
		else $error("preamble monitor enables not applied");

endmodule

// [verilog/rsm_pkg.sv]
// Constants shared by the receiver signal monitor control logic.
// Assumes a single 50 MHz clock domain and an AHB-Lite register slave.
// Function
// R01: Top two bits give expected data gaps
// R02: Bits five-four pick data phase slicer
// R03: Wakeup coding selector: any, short, long, Manchester
// R04: Preamble coding bit adds Manchester check
// R05: Data coding bit adds Manchester check
// R06: Mode zero: first fail or all pass
// R07: Mode one: all pass or timer fail
// R08: Wakeup register bits six-one enable monitors
// R09: Preamble register bits six-one enable monitors
// R10: Preamble bit seven reuses wakeup timeout
// R11: Accumulate bit collects preamble errors
// R12: Accumulator cleared at start and status read; code clears it on preamble start and on an accumulator read
// R13: Slicer codes: edge, held, short, long filter
// R14: Zero timeout count disables the timer
// R15: Data monitor fault raises end-of-frame flag
// R16: Wakeup register bit zero reads zero
package rsm_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_DATA_RX   = 8'h2d;
	localparam logic [7:0] IDX_WAKEUP    = 8'h2e;
	localparam logic [7:0] IDX_PREAMBLE  = 8'h2f;
	localparam logic [7:0] IDX_TIMEOUT   = 8'h31;
	localparam logic [7:0] IDX_STATUS    = 8'h40;
	localparam logic [7:0] IDX_MASK      = 8'h41;
	localparam logic [7:0] IDX_ACCUM     = 8'h42;
	localparam int         ADDR_LSB      = 2;

	// Reset values
	localparam logic [7:0] RST_DATA_RX   = 8'h00;
	localparam logic [7:0] RST_WAKEUP    = 8'h00;
	localparam logic [7:0] RST_PREAMBLE  = 8'h00;
	localparam logic [5:0] RST_TIMEOUT   = 6'h00;

	// Field positions
	localparam int GAP_HI      = 7;
	localparam int GAP_LO      = 6;
	localparam int SLC_HI      = 5;
	localparam int SLC_LO      = 4;
	localparam int CODW_HI     = 3;
	localparam int CODW_LO     = 2;
	localparam int CODP_BIT    = 1;
	localparam int CODD_BIT    = 0;
	localparam int MODE_BIT    = 7;
	localparam int REUSE_BIT   = 7;
	localparam int ACCU_BIT    = 0;
	localparam int MON_HI      = 6;
	localparam int MON_LO      = 1;
	localparam int MON_CODING  = 4;
	localparam logic [7:0] WAKEUP_WMASK = 8'hfe;

	// Coding policies
	localparam logic [1:0] COD_ANY   = 2'h0;
	localparam logic [1:0] COD_SHORT = 2'h1;
	localparam logic [1:0] COD_LONG  = 2'h2;
	localparam logic [1:0] COD_MANCH = 2'h3;

	// Slicer selections
	localparam logic [1:0] SLC_EDGE     = 2'h0;
	localparam logic [1:0] SLC_HELD     = 2'h1;
	localparam logic [1:0] SLC_LPF_SHRT = 2'h2;
	localparam logic [1:0] SLC_LPF_LONG = 2'h3;

	// Interrupt status bits
	localparam int ST_WAKE_PASS = 0;
	localparam int ST_WAKE_FAIL = 1;
	localparam int ST_PRE_ERR   = 2;
	localparam int ST_DATA_EOF  = 3;
	localparam int ST_W         = 4;

	typedef enum logic [1:0] {
		PH_IDLE     = 2'b00,
		PH_WAKEUP   = 2'b01,
		PH_PREAMBLE = 2'b10,
		PH_DATA     = 2'b11
	} rsm_phase_t;

endpackage
